/* pam_mgmt_regs.sv */
// management register bank of the pcs with its serial management slave
//
// Overview of operation
// - extended status bit 15 always reads one; writes never change it
// - extended status bits 14 to 0 always read zero
// - with interrupt enabled, completed auto-negotiation sets interrupt status bit 1
// - while interrupt enable is zero, interrupt status is held at zero
// - interrupt output pin follows the interrupt status bit at all times
// - interrupt enable bit 0 is read/write, resets to one; bits 15:2 read zero
// - undefined addresses read all zeros and ignore writes
// - main reset, lost clock-manager lock, soft reset each restore all defaults
// - 2500BASE-X rate presents the same registers and behaviour as 1000BASE-X
// - 1000BASE-X build without auto-negotiation defines only address 15
// - SGMII build with auto-negotiation defines addresses 4, 5, 15 and 16
// - 2.5G SGMII keeps the 1G layout but ignores speed selection fields except in the MAC mode advertisement
// - SGMII MAC mode advertisement is read-only, resets to zero
// - advertisement register is also loadable from the configuration vector input
// - PHY mode advertisement: bit15 link rw, bit13 zero, bits 9:1 zero, bit0 one
// - acknowledge bit 14 is read/write in PHY mode advertisement, read-only in partner
// - bit 12 duplex, bits 11:10 speed in registers 4 and 5; reset zero in register 4, read live in register 5
// - partner register read-only: link, duplex, speed; bit13, 9:1 zero; bit0 one
`timescale 1ns/1ps
`default_nettype none
`include "pam_defs.svh"

module pam_mgmt_regs
    import pam_pkg::*;
#(
    parameter bit SGMII_WITH_AN = 1'b1,
    parameter bit PHY_MODE      = 1'b0,
    parameter bit RATE_2G5      = 1'b0
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        mdc,
    input  wire logic        mdioIn,
    output var  logic        mdioOut,
    output var  logic        mdioOeN,
    input  wire logic [4:0]  phyAddr,
    input  wire logic        clockManagerLockedIn,
    input  wire logic        softResetIn,
    input  wire logic        anCompleteIn,
    input  wire logic        anAdvConfigValid,
    input  wire logic [15:0] anAdvConfigVector,
    input  wire logic        partnerLinkUp,
    input  wire logic        partnerAck,
    input  wire logic        partnerFullDuplex,
    input  wire logic [1:0]  partnerSpeed,
    output var  logic        autonegDoneIrqOut
);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic mdcMeta_reg;
    logic mdcSync_reg;
    logic mdcPrev_reg;
    logic mdioMeta_reg;
    logic mdioSync_reg;
    logic lockMeta_reg;
    logic lockSync_reg;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mdcMeta_reg  <= 1'b0;
            mdcSync_reg  <= 1'b0;
            mdcPrev_reg  <= 1'b0;
            mdioMeta_reg <= 1'b1;
            mdioSync_reg <= 1'b1;
            lockMeta_reg <= 1'b0;
            lockSync_reg <= 1'b0;
        end else begin
            mdcMeta_reg  <= mdc;
            mdcSync_reg  <= mdcMeta_reg;
            mdcPrev_reg  <= mdcSync_reg;
            mdioMeta_reg <= mdioIn;
            mdioSync_reg <= mdioMeta_reg;
            lockMeta_reg <= clockManagerLockedIn;
            lockSync_reg <= lockMeta_reg;
        end
    end

    logic mdcRise;
    logic mdcFall;
    logic regClear;

    assign mdcRise  = mdcSync_reg & ~mdcPrev_reg;
    assign mdcFall  = ~mdcSync_reg & mdcPrev_reg;
    assign regClear = ~lockSync_reg | softResetIn;

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    logic [15:0] advert_reg;
    logic        irqEnable_reg;
    logic        irqStatus_reg;
    logic        wrStrobe;
    logic [4:0]  wrAddr;
    logic [15:0] wrData;

    logic [15:0] advWriteMask;
    logic        advWrite;

    // compares a frame's register address with one decoded offset
    function automatic logic addrHit(input logic [4:0] addr, input logic [4:0] target);
        addrHit = addr == target;
    endfunction

    // speed bits carry no meaning at the single 2.5G rate
    assign advWriteMask = RATE_2G5 ? `PAM_ADV_PHY_WMASK25 : `PAM_ADV_PHY_WMASK;
    // mac mode keeps the register read-only; only the configuration vector loads it
    assign advWrite     = wrStrobe && addrHit(wrAddr, `PAM_ADDR_ADVERT) && SGMII_WITH_AN && PHY_MODE;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            advert_reg <= `PAM_ADV_RESET;
        end else if (regClear) begin
            advert_reg <= `PAM_ADV_RESET;
        end else if (anAdvConfigValid) begin
            if (PHY_MODE)
                advert_reg <= anAdvConfigVector & advWriteMask;
            else
                advert_reg <= anAdvConfigVector;
        end else if (advWrite) begin
            advert_reg <= wrData & advWriteMask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt control

    logic irqWrite;

    assign irqWrite = wrStrobe && addrHit(wrAddr, `PAM_ADDR_IRQ_CTRL) && SGMII_WITH_AN;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqEnable_reg <= `PAM_IRQ_EN_RESET;
        end else if (regClear) begin
            irqEnable_reg <= `PAM_IRQ_EN_RESET;
        end else if (irqWrite) begin
            irqEnable_reg <= wrData[`PAM_IRQ_EN_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqStatus_reg <= `PAM_IRQ_STAT_RESET;
        end else if (regClear || !irqEnable_reg || !SGMII_WITH_AN) begin
            irqStatus_reg <= 1'b0;
        end else if (anCompleteIn) begin
            irqStatus_reg <= 1'b1;
        end else if (irqWrite && !wrData[`PAM_IRQ_STAT_BIT]) begin
            irqStatus_reg <= 1'b0;
        end
    end

    assign autonegDoneIrqOut = irqStatus_reg;

    ////////////////////////////////////////////////////////////////////////////
    // read decode

    logic [1:0]  partnerSpeedSeen;
    logic [15:0] partnerWord;
    logic [15:0] advertWord;
    logic [15:0] irqWord;

    // the single 2.5G rate leaves the speed field without meaning, so it reads 00
    assign partnerSpeedSeen = RATE_2G5 ? 2'h0 : partnerSpeed;
    // partner fields are read live; bit 13 and bits 9:1 fixed zero, bit 0 fixed one
    assign partnerWord      = {partnerLinkUp, partnerAck, 1'b0, partnerFullDuplex, partnerSpeedSeen,
                               9'h000, 1'b1};
    assign advertWord       = PHY_MODE ? (advert_reg | `PAM_ADV_FIXED_ONES) : advert_reg;
    assign irqWord          = {14'h0000, irqStatus_reg, irqEnable_reg};

    ////////////////////////////////////////////////////////////////////////////
    // read word selection

    // extended status is the same fixed word in every build and at either rate
    function automatic logic [15:0] readValue(input logic [4:0] addr);
        readValue = 16'h0000;
        if (addrHit(addr, `PAM_ADDR_EXT_STATUS)) begin
            readValue = `PAM_EXT_STATUS_VALUE;
        end else if (SGMII_WITH_AN) begin
            unique case (addr)
                `PAM_ADDR_ADVERT: begin
                    readValue = advertWord;
                end
                `PAM_ADDR_PARTNER: begin
                    readValue = partnerWord;
                end
                `PAM_ADDR_IRQ_CTRL: begin
                    readValue = irqWord;
                end
                default: begin
                    readValue = 16'h0000;
                end
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // serial management frame engine

    pam_frame_e  frame_reg;
    logic [5:0]  preCnt_reg;
    logic [4:0]  bitCnt_reg;
    logic [15:0] shift_reg;
    logic [4:0]  regAddr_reg;
    logic        isRead_reg;
    logic        wrStrobe_reg;
    logic [13:0] header;

    assign header   = {shift_reg[12:0], mdioSync_reg};
    assign wrStrobe = wrStrobe_reg;
    assign wrAddr   = regAddr_reg;
    assign wrData   = shift_reg;

    ////////////////////////////////////////////////////////////////////////////
    // header field decode

    logic [1:0] hdrStart;
    logic [1:0] hdrOpcode;
    logic [4:0] hdrPhyAddr;
    logic [4:0] hdrRegAddr;
    logic       hdrOpValid;
    logic       hdrAccept;
    logic       lastDataRise;

    assign hdrStart     = header[13:12];
    assign hdrOpcode    = header[11:10];
    assign hdrPhyAddr   = header[9:5];
    assign hdrRegAddr   = header[4:0];
    // only the read and write opcodes are answered; anything else is dropped silently
    assign hdrOpValid   = hdrOpcode == `PAM_OP_READ || hdrOpcode == `PAM_OP_WRITE;
    assign hdrAccept    = hdrStart == `PAM_ST_CODE && hdrPhyAddr == phyAddr && hdrOpValid;
    assign lastDataRise = mdcRise && frame_reg == PAM_DATA && bitCnt_reg == `PAM_DATA_LAST;

    ////////////////////////////////////////////////////////////////////////////
    // write strobe, one cycle once the sixteenth data bit of a write is in

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrStrobe_reg <= 1'b0;
        end else begin
            wrStrobe_reg <= lastDataRise && !isRead_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame state

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_reg    <= PAM_PREAMBLE;
            preCnt_reg   <= 6'h00;
            bitCnt_reg   <= 5'h00;
            shift_reg    <= 16'h0000;
            regAddr_reg  <= 5'h00;
            isRead_reg   <= 1'b0;
        end else begin
            if (mdcRise) begin
                unique case (frame_reg)
                    PAM_PREAMBLE: begin
                        if (mdioSync_reg) begin
                            if (preCnt_reg != `PAM_PREAMBLE_LEN)
                                preCnt_reg <= preCnt_reg + 6'h01;
                        end else if (preCnt_reg == `PAM_PREAMBLE_LEN) begin
                            frame_reg  <= PAM_HEADER;
                            shift_reg  <= 16'h0000;
                            bitCnt_reg <= 5'h01;
                            preCnt_reg <= 6'h00;
                        end else begin
                            preCnt_reg <= 6'h00;
                        end
                    end
                    PAM_HEADER: begin
                        shift_reg  <= {shift_reg[14:0], mdioSync_reg};
                        bitCnt_reg <= bitCnt_reg + 5'h01;
                        if (bitCnt_reg == `PAM_HDR_LAST) begin
                            bitCnt_reg  <= 5'h00;
                            regAddr_reg <= hdrRegAddr;
                            isRead_reg  <= hdrOpcode == `PAM_OP_READ;
                            shift_reg   <= readValue(hdrRegAddr);
                            if (hdrAccept)
                                frame_reg <= PAM_TURN;
                            else
                                frame_reg <= PAM_PREAMBLE;
                        end
                    end
                    PAM_TURN: begin
                        bitCnt_reg <= bitCnt_reg + 5'h01;
                        if (bitCnt_reg == `PAM_TA_LAST) begin
                            bitCnt_reg <= 5'h00;
                            frame_reg  <= PAM_DATA;
                        end
                    end
                    PAM_DATA: begin
                        bitCnt_reg <= bitCnt_reg + 5'h01;
                        if (isRead_reg)
                            shift_reg <= {shift_reg[14:0], 1'b0};
                        else
                            shift_reg <= {shift_reg[14:0], mdioSync_reg};
                        if (bitCnt_reg == `PAM_DATA_LAST) begin
                            bitCnt_reg <= 5'h00;
                            frame_reg  <= PAM_PREAMBLE;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data pin driver, drives on falling edges of the management clock, releases after the last data rise

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mdioOut <= 1'b1;
            mdioOeN <= 1'b1;
        end else if (!isRead_reg || frame_reg == PAM_PREAMBLE || frame_reg == PAM_HEADER) begin
            mdioOut <= 1'b1;
            mdioOeN <= 1'b1;
        end else if (mdcFall) begin
            if (frame_reg == PAM_TURN && bitCnt_reg == `PAM_TA_LAST) begin
                mdioOut <= 1'b0;
                mdioOeN <= 1'b0;
            end else if (frame_reg == PAM_DATA) begin
                mdioOut <= shift_reg[15];
                mdioOeN <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

/* pam_defs.svh */
// register offsets, field positions, reset values and frame constants of the management bank
`ifndef PAM_DEFS_SVH
`define PAM_DEFS_SVH

`define PAM_ADDR_ADVERT      5'h04
`define PAM_ADDR_PARTNER     5'h05
`define PAM_ADDR_EXT_STATUS  5'h0f
`define PAM_ADDR_IRQ_CTRL    5'h10

`define PAM_EXT_STATUS_VALUE 16'h8000
`define PAM_ADV_PHY_WMASK    16'hdc00
`define PAM_ADV_PHY_WMASK25  16'hd000
`define PAM_ADV_FIXED_ONES   16'h0001
`define PAM_ADV_RESET        16'h0000

`define PAM_IRQ_EN_BIT       0
`define PAM_IRQ_STAT_BIT     1
`define PAM_IRQ_EN_RESET     1'b1
`define PAM_IRQ_STAT_RESET   1'b0

`define PAM_PREAMBLE_LEN     6'h20
`define PAM_HDR_LAST         5'h0d
`define PAM_DATA_LAST        5'h0f
`define PAM_TA_LAST          5'h01
`define PAM_ST_CODE          2'h1
`define PAM_OP_WRITE         2'h1
`define PAM_OP_READ          2'h2

`endif

/* pam_pkg.sv */
// types shared by the management bank
package pam_pkg;
    typedef enum logic [1:0] {
        PAM_PREAMBLE,
        PAM_HEADER,
        PAM_TURN,
        PAM_DATA
    } pam_frame_e;
endpackage

/* pam_mgmt_regs_asserts.sv */
// port-level assertions for the management register bank
`timescale 1ns/1ps
`default_nettype none
module pam_mgmt_regs_asserts (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic mdc,
    input wire logic mdioOut,
    input wire logic mdioOeN,
    input wire logic clockManagerLockedIn,
    input wire logic softResetIn,
    input wire logic anCompleteIn,
    input wire logic autonegDoneIrqOut
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence mgmtIdle;
        !mdc [*8];
    endsequence
    sequence irqHeld;
        (autonegDoneIrqOut && !mdc && !softResetIn && clockManagerLockedIn) [*6];
    endsequence
    a_irq_set_cause: assert property ($rose(autonegDoneIrqOut) |-> $past(anCompleteIn))
        else $error("irq rose without completion");
    a_irq_stays_set: assert property (irqHeld |=> autonegDoneIrqOut)
        else $error("irq dropped without a write");
    a_soft_clears_irq: assert property (softResetIn |=> !autonegDoneIrqOut)
        else $error("irq kept through soft reset");
    a_lock_clears_irq: assert property (!clockManagerLockedIn [*4] |=> !autonegDoneIrqOut)
        else $error("irq kept through lost lock");
    a_idle_no_drive: assert property (mgmtIdle |-> mdioOeN)
        else $error("data pin driven while clock idle");
    a_release_high: assert property (mdioOeN |-> mdioOut)
        else $error("data out low while released");
    a_turn_drives_zero: assert property ($fell(mdioOeN) |-> !mdioOut && !mdc)
        else $error("turnaround not driven low");
    a_drive_holds: assert property ($fell(mdioOeN) |-> !mdioOeN [*8])
        else $error("read drive dropped early");
endmodule
bind pam_mgmt_regs pam_mgmt_regs_asserts chk (.core_clk, .arst_n, .mdc, .mdioOut, .mdioOeN,
    .clockManagerLockedIn, .softResetIn, .anCompleteIn, .autonegDoneIrqOut);
`default_nettype wire

/* pam_mdio_master.sv */
// station management master model making serial frames
`timescale 1ns/1ps
`default_nettype none
module pam_mdio_master (
    output var  logic mdc,
    output var  logic drvOut,
    output var  logic drvEn,
    input  wire logic line
);
    initial begin
        mdc = 1'b0;
        drvOut = 1'b1;
        drvEn = 1'b0;
    end
    // data set while the clock is low, sampled on the rise
    task automatic bitx(input logic en, input logic d, output logic s);
        drvEn = en;
        drvOut = d;
        #100 mdc = 1'b1;
        s = line;
        #100 mdc = 1'b0;
    endtask
    // fresh preamble per frame; the clock stands low between frames
    task automatic frame(input logic [4:0] pa, input logic [1:0] op, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        logic        s;
        f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
        for (int i = 63; i >= 0; i--) begin
            bitx(i > 17 || op == 2'h1, f[i], s);
            if (i < 16) rd[i] = s;
        end
        drvEn = 1'b0;
    endtask
endmodule
`default_nettype wire

/* pam_mgmt_regs_tb.sv */
// self-checking bench for the management register bank
`timescale 1ns/1ps
`default_nettype none
module pam_mgmt_regs_tb;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        softRst = 1'b0;
    logic        lockIn = 1'b1;
    logic        anDone = 1'b0;
    logic        cfgValid = 1'b0;
    logic [15:0] cfgVector = 16'h2aaa;
    logic [3:0]  partner = 4'h0;
    logic [1:0]  speed = 2'h0;
    logic [15:0] rd;
    int          numErrors = 0;
    int          nChecks = 0;
    wire         mdc, drvOut, drvEn, mdioOut, mdioOeN, irqOut;
    // pulled-up data wire
    wire         line = !mdioOeN ? mdioOut : (drvEn ? drvOut : 1'b1);
    pam_mgmt_regs #(.PHY_MODE(1'b1)) uut (.core_clk(core_clk), .arst_n(arst_n), .mdc(mdc),
        .mdioIn(line), .mdioOut(mdioOut), .mdioOeN(mdioOeN), .phyAddr(5'h03),
        .clockManagerLockedIn(lockIn), .softResetIn(softRst), .anCompleteIn(anDone),
        .anAdvConfigValid(cfgValid), .anAdvConfigVector(cfgVector), .partnerLinkUp(partner[0]),
        .partnerAck(partner[1]), .partnerFullDuplex(partner[2]), .partnerSpeed(speed),
        .autonegDoneIrqOut(irqOut));
    pam_mdio_master mst (.mdc(mdc), .drvOut(drvOut), .drvEn(drvEn), .line(line));
    always #12.5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        @(posedge core_clk) #2;
        mst.frame(5'h03, 2'h1, ra, wd, rd);
        repeat (8) @(posedge core_clk);
    endtask
    task automatic rchk(input logic [4:0] ra, input logic [15:0] exp);
        @(posedge core_clk) #2;
        mst.frame(5'h03, 2'h2, ra, 16'h0000, rd);
        check($sformatf("reg %h", ra), rd, exp);
    endtask
    task automatic pulse(ref logic s);
        @(posedge core_clk) #2 s = 1'b1;
        @(posedge core_clk) #2 s = 1'b0;
    endtask
    task automatic summarize();
        if (numErrors == 0 && nChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1500000;
        numErrors++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        #2 arst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        rchk(5'h0f, 16'h8000);
        rchk(5'h10, 16'h0001);
        rchk(5'h04, 16'h0001);
        rchk(5'h05, 16'h0001);
        wr(5'h0f, 16'hffff);
        rchk(5'h0f, 16'h8000);
        pulse(anDone);
        check("irq set", {15'h0000, irqOut}, 16'h0001);
        rchk(5'h10, 16'h0003);
        wr(5'h10, 16'hffff);
        rchk(5'h10, 16'h0003);
        wr(5'h10, 16'h0001);
        rchk(5'h10, 16'h0001);
        check("irq clear", {15'h0000, irqOut}, 16'h0000);
        wr(5'h10, 16'h0000);
        pulse(anDone);
        rchk(5'h10, 16'h0000);
        wr(5'h10, 16'h0001);
        pulse(anDone);
        wr(5'h10, 16'h0000);
        rchk(5'h10, 16'h0000);
        wr(5'h04, 16'hffff);
        rchk(5'h04, 16'hdc01);
        pulse(cfgValid);
        rchk(5'h04, 16'h0801);
        #2 partner = 4'h7;
        speed = 2'h2;
        wr(5'h05, 16'h0000);
        rchk(5'h05, 16'hd801);
        for (int a = 17; a < 32; a += 7) begin
            wr(5'(a), 16'hffff);
            rchk(5'(a), 16'h0000);
        end
        wr(5'h04, 16'hffff);
        pulse(softRst);
        rchk(5'h04, 16'h0001);
        rchk(5'h10, 16'h0001);
        wr(5'h04, 16'hffff);
        pulse(anDone);
        @(posedge core_clk) #2 lockIn = 1'b0;
        repeat (10) @(posedge core_clk);
        #2 lockIn = 1'b1;
        repeat (4) @(posedge core_clk);
        rchk(5'h04, 16'h0001);
        check("irq lock", {15'h0000, irqOut}, 16'h0000);
        wr(5'h10, 16'h0000);
        @(posedge core_clk) #2 arst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #2 arst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        rchk(5'h10, 16'h0001);
        mst.frame(5'h05, 2'h1, 5'h10, 16'h0000, rd);
        rchk(5'h10, 16'h0001);
        mst.frame(5'h05, 2'h2, 5'h10, 16'h0000, rd);
        check("foreign read", rd, 16'hffff);
        summarize();
    end
endmodule
`default_nettype wire
